// >>> fcrc_pkg.sv
// Package for the frame checksum generator and checker.
// Assumes a single 10 MHz system clock shared by both link ends.
package fcrc_pkg;

  // ***************************************************
  // Frame layout
  // ***************************************************
  localparam int FRAME_W = 48;
  localparam int CRC_W = 8;
  localparam int MSG_W = FRAME_W - CRC_W;
  localparam int CNT_W = 6;
  localparam logic [CRC_W-1:0] CRC_POLY = 8'h2f;
  localparam logic [CRC_W-1:0] CRC_SEED = 8'hff;
  localparam logic [CRC_W-1:0] CRC_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] BIT_LAST = 6'h2f;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam int ERR_W = 8;
  localparam logic [ERR_W-1:0] ERR_ONE = 8'h01;
  localparam logic [ERR_W-1:0] ERR_ZERO = 8'h00;
  localparam logic [ERR_W-1:0] ERR_MAX = 8'hff;

  typedef enum logic [1:0] {FC_IDLE, FC_RUN, FC_DONE} fcrc_state_e;

  // One bit-serial checksum step: shift in, conditional divide
  function automatic logic [CRC_W-1:0] fcrc_step(input logic [CRC_W-1:0] crc,
                                                 input logic din);
    logic msb;
    msb = crc[CRC_W-1];
    fcrc_step = {crc[CRC_W-2:0], din};
    if (msb) begin
      fcrc_step = fcrc_step ^ CRC_POLY;
    end
  endfunction : fcrc_step

endpackage : fcrc_pkg

// >>> fcrc_link_if.sv
// Interface joining a frame sender end and a frame receiver end.
// Assumes one clock; frames pass as a 48-bit word with a one-cycle valid.
`timescale 1ns/10ps
interface fcrc_link_if;
  import fcrc_pkg::*;
  logic frameValid;
  logic [FRAME_W-1:0] frame;
  logic busy;

  modport sender (output frameValid, output frame, input busy);
  modport receiver (input frameValid, input frame, output busy);
endinterface : fcrc_link_if

// >>> fcrc_sender.sv
// Transmit end: appends the 8-bit checksum to a 40-bit message.
// Assumes the receiver end takes frames through fcrc_link_if.
`timescale 1ns/10ps
module fcrc_sender
  import fcrc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic msgValid,
  input wire logic [MSG_W-1:0] msgData,
  output logic msgReady,
  fcrc_link_if.sender link
);

  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    fcrc_state_e state;
    logic [CRC_W-1:0] crc;
    logic [FRAME_W-1:0] shifter;
    logic [MSG_W-1:0] msg;
    logic [CNT_W-1:0] cnt;
    logic frameValid;
    logic [FRAME_W-1:0] frame;
    logic ready;
  } fcrc_tx_s;

  fcrc_tx_s st_r;
  fcrc_tx_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.frameValid = 1'b0;
    case (st_r.state)
      FC_IDLE: begin
        st_nxt.ready = ~link.busy;
        if (msgValid && st_r.ready) begin
          st_nxt.crc = CRC_SEED;
          st_nxt.shifter = {msgData, CRC_ZERO};
          st_nxt.msg = msgData;
          st_nxt.cnt = CNT_ZERO;
          st_nxt.ready = 1'b0;
          st_nxt.state = FC_RUN;
        end
      end
      FC_RUN: begin
        // One bit per cycle, MSB first, zeros last
        st_nxt.crc = fcrc_step(st_r.crc, st_r.shifter[FRAME_W-1]);
        st_nxt.shifter = {st_r.shifter[FRAME_W-2:0], 1'b0};
        st_nxt.cnt = st_r.cnt + CNT_ONE;
        if (st_r.cnt == BIT_LAST) begin
          st_nxt.state = FC_DONE;
        end
      end
      FC_DONE: begin
        // Remainder replaces the zero byte
        st_nxt.frame = {st_r.msg, st_r.crc};
        st_nxt.frameValid = 1'b1;
        st_nxt.state = FC_IDLE;
      end
      default: st_nxt.state = FC_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  assign msgReady = st_r.ready;
  assign link.frameValid = st_r.frameValid;
  assign link.frame = st_r.frame;

endmodule : fcrc_sender

// >>> fcrc_receiver.sv
// Receive end: checks the 8-bit checksum of each 48-bit frame.
// Assumes the sender end drives fcrc_link_if on the same clock,
// and only offers a frame while busy is low: a frame that arrives
// during a check is dropped without any sign.
// Assumes linkErrorFaultClear comes from logic on the same clock.
`timescale 1ns/10ps
module fcrc_receiver
  import fcrc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic linkErrorFaultClear,
  fcrc_link_if.receiver link,
  output logic checkDone,
  output logic frameGood,
  output logic frameBad,
  output logic [FRAME_W-1:0] rxFrame,
  output logic replyAllowed,
  output logic retryRequest,
  output logic linkErrorFaultFlag,
  output logic [ERR_W-1:0] linkErrorCount
);

  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    fcrc_state_e state;
    logic [CRC_W-1:0] crc;
    logic [FRAME_W-1:0] shifter;
    logic [FRAME_W-1:0] frame;
    logic [CNT_W-1:0] cnt;
    logic busy;
    logic done;
    logic good;
    logic bad;
    logic reply;
    logic retry;
    logic fault;
    logic [ERR_W-1:0] errCnt;
  } fcrc_rx_s;

  fcrc_rx_s st_r;
  fcrc_rx_s st_nxt;

  // ***************************************************
  // Checksum step
  // ***************************************************
  // Own per-bit taps rather than the sender's helper, so a slip in
  // one end does not hide behind the same slip in the other
  wire logic [CRC_W-1:0] stepCrc;
  wire logic remainderZero;

  for (genvar i = 0; i < CRC_W; i++) begin : g_step
    if (i == 0) begin : g_low
      assign stepCrc[i] = st_r.shifter[FRAME_W-1] ^ (st_r.crc[CRC_W-1] & CRC_POLY[i]);
    end else begin : g_up
      assign stepCrc[i] = st_r.crc[i-1] ^ (st_r.crc[CRC_W-1] & CRC_POLY[i]);
    end
  end

  assign remainderZero = (st_r.crc == CRC_ZERO);

  // ***************************************************
  // Next state
  // ***************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.reply = 1'b0;
    st_nxt.retry = 1'b0;
    // Software clear; a same-cycle failure below wins
    if (linkErrorFaultClear) begin
      st_nxt.fault = 1'b0;
    end
    case (st_r.state)
      FC_IDLE: begin
        if (link.frameValid) begin
          st_nxt.crc = CRC_SEED;
          st_nxt.shifter = link.frame;
          st_nxt.frame = link.frame;
          st_nxt.cnt = CNT_ZERO;
          st_nxt.busy = 1'b1;
          // Verdict of previous frame cleared at next start
          st_nxt.good = 1'b0;
          st_nxt.bad = 1'b0;
          st_nxt.state = FC_RUN;
        end
      end
      FC_RUN: begin
        // Checksum byte included, arrival order
        // Top bit out folds the polynomial
        st_nxt.crc = stepCrc;
        st_nxt.shifter = {st_r.shifter[FRAME_W-2:0], 1'b0};
        st_nxt.cnt = st_r.cnt + CNT_ONE;
        if (st_r.cnt == BIT_LAST) begin
          st_nxt.state = FC_DONE;
        end
      end
      FC_DONE: begin
        st_nxt.done = 1'b1;
        st_nxt.busy = 1'b0;
        st_nxt.state = FC_IDLE;
        // Reply only on a clean frame; a bad one pulses retry instead
        if (remainderZero) begin
          st_nxt.good = 1'b1;
          st_nxt.reply = 1'b1;
        end else begin
          st_nxt.bad = 1'b1;
          st_nxt.retry = 1'b1;
          st_nxt.fault = 1'b1;
          if (st_r.errCnt != ERR_MAX) begin
            st_nxt.errCnt = st_r.errCnt + ERR_ONE;
          end
        end
      end
      default: st_nxt.state = FC_IDLE;
    endcase
  end

  // ***************************************************
  // Registers
  // ***************************************************
  // Low clkEn freezes every field, one-cycle pulses included
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign link.busy = st_r.busy;
  assign checkDone = st_r.done;
  assign frameGood = st_r.good;
  assign frameBad = st_r.bad;
  assign rxFrame = st_r.frame;
  assign replyAllowed = st_r.reply;
  assign retryRequest = st_r.retry;
  assign linkErrorFaultFlag = st_r.fault;
  assign linkErrorCount = st_r.errCnt;

endmodule : fcrc_receiver

// >>> fcrc_assertions.sv
// Checker on the link between the sender and receiver ends.
// Assumes the clock enable is held high.
`timescale 1ns/10ps
module fcrc_assertions
  import fcrc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic frameValid,
  input wire logic [FRAME_W-1:0] frame,
  input wire logic busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  function automatic logic [7:0] crcOf(input logic [47:0] f);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 47; i >= 0; i--) begin
      c = {c[6:0], (i > 7) ? f[i] : 1'b0} ^ (c[7] ? 8'h2f : 8'h00);
    end
    return c;
  endfunction : crcOf
  sequence s_run; busy [*8]; endsequence
  sequence s_quiet; !frameValid [*8]; endsequence
  property p_pulse; frameValid |=> s_quiet; endproperty
  property p_take; frameValid |=> busy; endproperty
  property p_idle; frameValid |-> !busy; endproperty
  property p_run; $rose(busy) |-> s_run; endproperty
  property p_len; $rose(busy) |-> ##49 $fell(busy); endproperty
  property p_cause; $rose(busy) |-> $past(frameValid); endproperty
  property p_crc; frameValid |-> frame[7:0] == crcOf(frame); endproperty
  property p_hold; busy |-> $stable(frame); endproperty
  a_pulse: assert property (p_pulse) else $error("valid too soon");
  a_take: assert property (p_take) else $error("frame not taken");
  a_idle: assert property (p_idle) else $error("sent while busy");
  a_run: assert property (p_run) else $error("check cut short");
  a_len: assert property (p_len) else $error("check length");
  a_cause: assert property (p_cause) else $error("busy uncaused");
  a_crc: assert property (p_crc) else $error("bad checksum");
  a_hold: assert property (p_hold) else $error("frame moved");
endmodule : fcrc_assertions

// >>> tb.sv
// Bench: sender joined to receiver, second receiver fed by hand.
// Assumes a 10 MHz clock and clock enable held high.
`timescale 1ns/10ps
module tb;
  import fcrc_pkg::*;
  logic clock = 0, rst_n = 0, en = 1, msgValid = 0, faultClear = 0;
  logic [MSG_W-1:0] msgData = '0;
  logic msgReady, done, good, bad, reply, retry, done2, good2, bad2, retry2, reply2, flag2;
  logic [ERR_W-1:0] cnt, cnt2;
  logic [FRAME_W-1:0] rx, rx2;
  int n_errors = 0, cmp_count = 0, cycles = 0;
  logic [47:0] vecs [8] = '{48'h01010801303c, 48'h0a0a010a9184, 48'h01c40f021226,
    48'h7257010573c7, 48'h110189013026, 48'h20028905907a, 48'h5103890a1507, 48'hff04890672a6};
  fcrc_link_if lnk();
  fcrc_link_if lnk2();
  fcrc_sender fcrc_sender_i(.clock, .rst_n, .clkEn(en), .msgValid, .msgData, .msgReady,
    .link(lnk));
  fcrc_receiver fcrc_receiver_i(.clock, .rst_n, .clkEn(en), .linkErrorFaultClear(faultClear),
    .link(lnk), .checkDone(done), .frameGood(good), .frameBad(bad), .rxFrame(rx),
    .replyAllowed(reply), .retryRequest(retry), .linkErrorFaultFlag(), .linkErrorCount(cnt));
  // Second end takes hand-made frames, so bad checksums can be sent
  fcrc_receiver fcrc_receiver_bad_i(.clock, .rst_n, .clkEn(en),
    .linkErrorFaultClear(faultClear), .link(lnk2), .checkDone(done2), .frameGood(good2),
    .frameBad(bad2), .rxFrame(rx2), .replyAllowed(reply2), .retryRequest(retry2),
    .linkErrorFaultFlag(flag2), .linkErrorCount(cnt2));
  fcrc_assertions fcrc_assertions_i(.clock, .rst_n, .frameValid(lnk.frameValid),
    .frame(lnk.frame), .busy(lnk.busy));
  initial forever #50 clock = ~clock;
  task automatic give_verdict();
    $display("Compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wait_done(ref logic d);
    repeat (120) begin
      @(negedge clock);
      if (d) break;
    end
    check("done", d, 1);
  endtask : wait_done
  task automatic test_encode();
    foreach (vecs[k]) begin
      @(negedge clock);
      msgData = vecs[k][47:8];
      msgValid = 1;
      while (!msgReady) @(negedge clock);
      @(negedge clock);
      msgValid = 0;
      wait_done(done);
      check("frame", lnk.frame, vecs[k]);
      check("verdict", {bad, good}, 2'b01);
      check("reply", reply, 1);
      check("rxframe", rx, vecs[k]);
      check("retry", retry, 0);
    end
    check("count", cnt, 0);
    $display("test_encode ended");
  endtask : test_encode
  task automatic send2(logic [47:0] f, logic [1:0] gb, logic [7:0] n);
    @(negedge clock);
    lnk2.frame = f;
    lnk2.frameValid = 1;
    @(negedge clock);
    lnk2.frameValid = 0;
    wait_done(done2);
    check("verdict", {bad2, good2}, gb);
    check("retry", retry2, gb[1]);
    check("count", cnt2, n);
    check("reply", reply2, gb[0]);
    check("rxframe", rx2, f);
    repeat (5) @(negedge clock);
    check("held", {bad2, good2}, gb);
  endtask : send2
  task automatic test_bad();
    send2(vecs[0] ^ 48'h1, 2'b10, 8'h01);
    send2(vecs[5] ^ 48'h800000000000, 2'b10, 8'h02);
    check("flag", flag2, 1);
    send2(vecs[2], 2'b01, 8'h02);
    faultClear = 1;
    @(negedge clock);
    faultClear = 0;
    @(negedge clock);
    check("cleared", flag2, 0);
    $display("test_bad ended");
  endtask : test_bad
  // Clear held through the verdict edge: the failure must still set the flag
  task automatic test_race();
    @(negedge clock);
    faultClear = 1;
    lnk2.frame = vecs[1] ^ 48'h100;
    lnk2.frameValid = 1;
    @(negedge clock);
    lnk2.frameValid = 0;
    wait_done(done2);
    check("race", flag2, 1);
    check("count", cnt2, 8'h03);
    check("reply", reply2, 0);
    faultClear = 0;
    $display("test_race ended");
  endtask : test_race
  initial begin
    lnk2.frameValid = 0;
    lnk2.frame = '0;
    repeat (10) @(negedge clock);
    rst_n = 1;
    test_encode();
    test_bad();
    test_race();
    give_verdict();
  end
endmodule : tb
